// ---- sdbt_bank.sv ----
`timescale 1ns/1ns
module sdbt_bank #(
	parameter int RP = sdbt_pkg::RP_CYC,
	parameter int RCD = sdbt_pkg::RCD_CYC,
	parameter int BL = sdbt_pkg::BURST_LEN_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input sdbt_pkg::sdbt_bank_evt_type evt,
	output sdbt_pkg::sdbt_bank_state_type state
);
	import sdbt_pkg::*;

	localparam sdbt_cnt_type RP_LD = CNT_W'(RP - 1);
	localparam sdbt_cnt_type RCD_LD = CNT_W'(RCD - 1);
	localparam sdbt_cnt_type BL_LD = CNT_W'(BL - 1);

	sdbt_cnt_type cnt_reg;
	logic expired;

	assign expired = (cnt_reg == '0);

	////////////////////////////////////////////////////////////////////////
	// Bank state and delay counter
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= BANK_IDLE;
			cnt_reg <= '0;
		end
		else
		begin
			if (!expired)
				cnt_reg <= cnt_reg - 1'b1;
			unique case (state)
				BANK_IDLE:
					if (evt.activate)
					begin
						state <= BANK_ACTIVATING;
						cnt_reg <= RCD_LD;
					end
				BANK_ACTIVATING:
					if (expired)
						state <= BANK_ACTIVE;
				BANK_ACTIVE, BANK_READ, BANK_WRITE:
					if (evt.precharge)
					begin
						state <= BANK_PRECHARGING;
						cnt_reg <= RP_LD;
					end
					else if (evt.read || evt.write)
					begin
						// New burst, optionally closing the row after it
						if (evt.read)
							state <= evt.auto_pre ? BANK_READ_AP : BANK_READ;
						else
							state <= evt.auto_pre ? BANK_WRITE_AP : BANK_WRITE;
						cnt_reg <= BL_LD;
					end
					else if (state != BANK_ACTIVE && (evt.cut || expired))
						state <= BANK_ACTIVE;
				BANK_READ_AP, BANK_WRITE_AP:
					if (evt.cut || expired)
					begin
						state <= BANK_PRECHARGING;
						cnt_reg <= RP_LD;
					end
				BANK_PRECHARGING:
					if (expired)
						state <= BANK_IDLE;
			endcase
		end
	end

endmodule : sdbt_bank

// ---- sdbt_host.sv ----
`timescale 1ns/1ns
module sdbt_host (
	input wire logic clk,
	input wire logic all_idle,
	output sdbt_pkg::sdbt_pins_type pins
);
	import sdbt_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pins from command code, bank and bit ten; clock enable always high
	function automatic sdbt_pins_type mk(input logic [3:0] c, input logic [1:0] b, input logic ap);
		return {c, 1'h1, b, ap};
	endfunction : mk

	// Deselected from time zero
	initial pins = mk(4'h8, 2'h0, 1'h0);

	// One command per falling edge; refresh and mode load wait for all idle
	task automatic put(input logic [3:0] c, input logic [1:0] b, input logic ap);
		@(negedge clk);
		while (c[3:1] == 3'h0 && !all_idle)
			@(negedge clk);
		pins = mk(c, b, ap);
	endtask : put

	// No-operation filler while a bank or the device is busy
	task automatic fill(input int n);
		put(4'h7, 2'h0, 1'h0);
		repeat (n - 1) @(negedge clk);
	endtask : fill

	// Self refresh entry with clock enable low, exit after n more cycles
	task automatic sleep(input int n);
		sdbt_pins_type p;
		@(negedge clk);
		while (!all_idle)
			@(negedge clk);
		p = mk(4'h1, 2'h0, 1'h0);
		p.cke = 1'h0;
		pins = p;
		@(negedge clk);
		p = mk(4'h7, 2'h0, 1'h0);
		p.cke = 1'h0;
		pins = p;
		repeat (n) @(negedge clk);
		pins = mk(4'h7, 2'h0, 1'h0);
	endtask : sleep
endmodule : sdbt_host

// ---- sdbt_pkg.sv ----
package sdbt_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and delay figures
	localparam int CLK_MHZ = 100;
	localparam int PRECHARGE_RECOVERY_TIME_NS = 20;
	localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 20;
	localparam int REFRESH_CYCLE_TIME_NS = 70;
	localparam int SELF_REFRESH_EXIT_DELAY_NS = 80;
	localparam int MODE_REGISTER_SET_DELAY_CK = 2;
	localparam int BURST_LEN_DEF = 4;
	localparam int CNT_W = 8;
	localparam int NUM_BANKS = 4;

	// Least time in ns to whole clocks, never below one
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc

	localparam int RP_CYC = ns_to_cyc(PRECHARGE_RECOVERY_TIME_NS);
	localparam int RCD_CYC = ns_to_cyc(ACTIVATE_TO_COLUMN_DELAY_NS);
	localparam int RFC_CYC = ns_to_cyc(REFRESH_CYCLE_TIME_NS);
	localparam int XSR_CYC = ns_to_cyc(SELF_REFRESH_EXIT_DELAY_NS);
	localparam int MRD_CYC = MODE_REGISTER_SET_DELAY_CK;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef logic [1:0] sdbt_bank_idx_type;
	typedef logic [CNT_W-1:0] sdbt_cnt_type;

	typedef enum logic [2:0] {
		BANK_IDLE = 3'h0,
		BANK_ACTIVATING = 3'h1,
		BANK_ACTIVE = 3'h3,
		BANK_READ = 3'h2,
		BANK_WRITE = 3'h6,
		BANK_READ_AP = 3'h7,
		BANK_WRITE_AP = 3'h5,
		BANK_PRECHARGING = 3'h4
	} sdbt_bank_state_type;

	typedef enum logic [2:0] {
		DEV_NORMAL = 3'h0,
		DEV_REFRESH = 3'h1,
		DEV_MODE = 3'h3,
		DEV_PRE_ALL = 3'h2,
		DEV_SELF_REF = 3'h6,
		DEV_SR_EXIT = 3'h7
	} sdbt_dev_state_type;

	typedef enum logic [3:0] {
		CMD_INHIBIT = 4'h0,
		CMD_NOP = 4'h1,
		CMD_ACTIVATE = 4'h2,
		CMD_READ = 4'h3,
		CMD_WRITE = 4'h4,
		CMD_TERMINATE = 4'h5,
		CMD_PRECHARGE = 4'h6,
		CMD_REFRESH = 4'h7,
		CMD_MODE_LOAD = 4'h8
	} sdbt_cmd_kind_type;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic cke;
		logic bank_select_bit1;
		logic bank_select_bit0;
		logic auto_precharge_addr_bit;
	} sdbt_pins_type;

	typedef struct packed {
		logic activate;
		logic read;
		logic write;
		logic auto_pre;
		logic precharge;
		logic cut;
	} sdbt_bank_evt_type;

	// Pins at reset: deselected, clock enable low
	localparam sdbt_pins_type PINS_RST = 8'hF0;

endpackage : sdbt_pkg

// ---- sdbt_tracker.sv ----
`timescale 1ns/1ns
// Overview of operation
// - Deselected cycles ignored, operations continue
// - No-operation continues any operation underway
// - Activate accepted only by idle bank
// - Precharge to idle bank changes nothing
// - Active bank takes read, write, precharge
// - Read burst takes read, write, stop, precharge
// - Write burst takes read, write, stop, precharge
// - Burst stop cuts most recent burst
// - Idle only after precharge recovery time
// - Active after activate-to-column delay, no burst
// - Precharge enters precharging, then idle
// - Activate enters activating, then row active
// - Read with auto precharge busy until idle
// - Write with auto precharge busy until idle
// - Refresh holds device for refresh cycle time
// - Mode load holds device for set delay
// - Precharge all holds device for recovery time
// - Tables apply with clock enable held high
// - Commands to other banks accepted by state
// - Address bit ten selects auto precharge
// - Address bit ten high precharges all banks
// - Two select bits pick target bank
module sdbt_tracker #(
	parameter int BURST_LEN = sdbt_pkg::BURST_LEN_DEF,
	parameter int RP = sdbt_pkg::RP_CYC,
	parameter int RCD = sdbt_pkg::RCD_CYC,
	parameter int RFC = sdbt_pkg::RFC_CYC,
	parameter int MRD = sdbt_pkg::MRD_CYC,
	parameter int XSR = sdbt_pkg::XSR_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input sdbt_pkg::sdbt_pins_type pins_in,
	output sdbt_pkg::sdbt_bank_state_type bank_state [sdbt_pkg::NUM_BANKS],
	output sdbt_pkg::sdbt_dev_state_type dev_state_reg,
	output logic all_idle_reg,
	output logic cmd_accepted_reg,
	output logic cmd_illegal_reg,
	output sdbt_pkg::sdbt_bank_idx_type burst_bank_reg
);
	import sdbt_pkg::*;

	localparam int CNT_LIMIT = 2 ** CNT_W;
	localparam sdbt_cnt_type RP_LD = CNT_W'(RP - 1);
	localparam sdbt_cnt_type RFC_LD = CNT_W'(RFC - 1);
	localparam sdbt_cnt_type MRD_LD = CNT_W'(MRD - 1);
	localparam sdbt_cnt_type XSR_LD = CNT_W'(XSR - 1);

	////////////////////////////////////////////////////////////////////////
	// Parameter checks
	if (BURST_LEN < 1 || BURST_LEN > CNT_LIMIT || RP < 1 || RP > CNT_LIMIT ||
		RCD < 1 || RCD > CNT_LIMIT || RFC < 1 || RFC > CNT_LIMIT ||
		MRD < 1 || MRD > CNT_LIMIT || XSR < 1 || XSR > CNT_LIMIT)
	begin : g_bad_param
		$error("sdbt_tracker: delay or burst length out of counter range");
	end

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Command pins to command kind; clock enable is judged separately
	function automatic sdbt_cmd_kind_type decode(input sdbt_pins_type p);
		sdbt_cmd_kind_type k;
		k = CMD_INHIBIT;
		if (!p.cs_n)
		begin
			unique case ({p.ras_n, p.cas_n, p.we_n})
				3'h7: k = CMD_NOP;
				3'h3: k = CMD_ACTIVATE;
				3'h5: k = CMD_READ;
				3'h4: k = CMD_WRITE;
				3'h6: k = CMD_TERMINATE;
				3'h2: k = CMD_PRECHARGE;
				3'h1: k = CMD_REFRESH;
				3'h0: k = CMD_MODE_LOAD;
			endcase
		end
		return k;
	endfunction : decode

	// Bank in one of the four burst states
	function automatic logic bursting(input sdbt_bank_state_type s);
		return (s == BANK_READ) || (s == BANK_WRITE) ||
			(s == BANK_READ_AP) || (s == BANK_WRITE_AP);
	endfunction : bursting

	// Same-bank acceptance of a bank-specific command
	function automatic logic accepts(input sdbt_bank_state_type s, input sdbt_cmd_kind_type k);
		logic ok;
		ok = 1'b0;
		unique case (k)
			CMD_ACTIVATE: ok = (s == BANK_IDLE);
			CMD_READ, CMD_WRITE: ok = (s == BANK_ACTIVE) || (s == BANK_READ) || (s == BANK_WRITE);
			CMD_PRECHARGE: ok = (s == BANK_IDLE) || (s == BANK_ACTIVE) || (s == BANK_READ) || (s == BANK_WRITE);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : accepts

	////////////////////////////////////////////////////////////////////////
	// Reset release
	logic [1:0] rst_sync_reg;
	logic rst_n;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	assign rst_n = rst_sync_reg[1];

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	sdbt_pins_type pin_s1_reg;
	sdbt_pins_type pins;
	logic cke_prev_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_reg <= PINS_RST;
			pins <= PINS_RST;
		end
		else
		begin
			pin_s1_reg <= pins_in;
			pins <= pin_s1_reg;
		end
	end

	// Clock enable at the previous edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cke_prev_reg <= 1'b0;
		else
			cke_prev_reg <= pins.cke;
	end

	////////////////////////////////////////////////////////////////////////
	// Command decode and legality
	sdbt_cmd_kind_type kind;
	sdbt_bank_idx_type tgt;
	sdbt_bank_evt_type evt [NUM_BANKS];
	logic cke_stable;
	logic tables_on;
	logic is_cmd;
	logic cmd_ok;
	logic all_banks_idle;
	logic all_idle;
	logic pre_all_ok;
	logic go_refresh;
	logic go_mode;
	logic go_pre_all;
	logic go_self_ref;

	assign kind = decode(pins);
	assign tgt = {pins.bank_select_bit1, pins.bank_select_bit0};
	assign cke_stable = cke_prev_reg && pins.cke;
	assign tables_on = cke_stable && (dev_state_reg == DEV_NORMAL);
	assign is_cmd = (kind != CMD_INHIBIT) && (kind != CMD_NOP);

	// Whole-device conditions
	always_comb
	begin
		all_banks_idle = 1'b1;
		pre_all_ok = 1'b1;
		for (int b = 0; b < NUM_BANKS; b++)
		begin
			if (bank_state[b] != BANK_IDLE)
				all_banks_idle = 1'b0;
			if (!accepts(bank_state[b], CMD_PRECHARGE))
				pre_all_ok = 1'b0;
		end
	end

	assign all_idle = all_banks_idle && (dev_state_reg == DEV_NORMAL);

	// Per-bank events from the registered command
	always_comb
	begin
		cmd_ok = 1'b0;
		for (int b = 0; b < NUM_BANKS; b++)
			evt[b] = '0;
		if (tables_on)
		begin
			unique case (kind)
				CMD_ACTIVATE:
					if (accepts(bank_state[tgt], kind))
					begin
						cmd_ok = 1'b1;
						evt[tgt].activate = 1'b1;
					end
				CMD_READ, CMD_WRITE:
					if (accepts(bank_state[tgt], kind))
					begin
						cmd_ok = 1'b1;
						evt[tgt].read = (kind == CMD_READ);
						evt[tgt].write = (kind == CMD_WRITE);
						evt[tgt].auto_pre = pins.auto_precharge_addr_bit;
						// A burst elsewhere is interrupted by this one
						for (int b = 0; b < NUM_BANKS; b++)
							if (b != int'(tgt) && bursting(bank_state[b]))
								evt[b].cut = 1'b1;
					end
				CMD_TERMINATE:
					if (bursting(bank_state[burst_bank_reg]))
					begin
						cmd_ok = 1'b1;
						evt[burst_bank_reg].cut = 1'b1;
					end
				CMD_PRECHARGE:
					if (pins.auto_precharge_addr_bit)
					begin
						if (pre_all_ok)
						begin
							cmd_ok = 1'b1;
							for (int b = 0; b < NUM_BANKS; b++)
								evt[b].precharge = (bank_state[b] != BANK_IDLE);
						end
					end
					else if (accepts(bank_state[tgt], kind))
					begin
						cmd_ok = 1'b1;
						evt[tgt].precharge = (bank_state[tgt] != BANK_IDLE);
					end
				CMD_REFRESH, CMD_MODE_LOAD:
					cmd_ok = all_idle;
				default:
					cmd_ok = 1'b0;
			endcase
		end
	end

	assign go_refresh = tables_on && (kind == CMD_REFRESH) && cmd_ok;
	assign go_mode = tables_on && (kind == CMD_MODE_LOAD) && cmd_ok;
	assign go_pre_all = tables_on && (kind == CMD_PRECHARGE) && pins.auto_precharge_addr_bit && cmd_ok;
	assign go_self_ref = cke_prev_reg && !pins.cke && (kind == CMD_REFRESH) && all_idle;

	////////////////////////////////////////////////////////////////////////
	// Banks
	for (genvar b = 0; b < NUM_BANKS; b++)
	begin : g_bank
		sdbt_bank #(
			.RP(RP),
			.RCD(RCD),
			.BL(BURST_LEN)
		) u_bank (
			.clk(clk),
			.rst_n(rst_n),
			.evt(evt[b]),
			.state(bank_state[b])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Device-wide state
	sdbt_cnt_type dev_cnt_reg;
	logic dev_expired;

	assign dev_expired = (dev_cnt_reg == '0);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dev_state_reg <= DEV_NORMAL;
			dev_cnt_reg <= '0;
		end
		else
		begin
			if (!dev_expired)
				dev_cnt_reg <= dev_cnt_reg - 1'b1;
			unique case (dev_state_reg)
				DEV_NORMAL:
					if (go_refresh)
					begin
						dev_state_reg <= DEV_REFRESH;
						dev_cnt_reg <= RFC_LD;
					end
					else if (go_mode)
					begin
						dev_state_reg <= DEV_MODE;
						dev_cnt_reg <= MRD_LD;
					end
					else if (go_pre_all)
					begin
						dev_state_reg <= DEV_PRE_ALL;
						dev_cnt_reg <= RP_LD;
					end
					else if (go_self_ref)
						dev_state_reg <= DEV_SELF_REF;
				DEV_REFRESH, DEV_MODE, DEV_PRE_ALL:
					if (dev_expired)
						dev_state_reg <= DEV_NORMAL;
				DEV_SELF_REF:
					if (pins.cke)
					begin
						dev_state_reg <= DEV_SR_EXIT;
						dev_cnt_reg <= XSR_LD;
					end
				DEV_SR_EXIT:
					if (dev_expired)
						dev_state_reg <= DEV_NORMAL;
				default:
				begin
					dev_state_reg <= DEV_NORMAL;
					dev_cnt_reg <= '0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Most recent burst bank
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			burst_bank_reg <= '0;
		else if (cmd_ok && (kind == CMD_READ || kind == CMD_WRITE))
			burst_bank_reg <= tgt;
	end

	////////////////////////////////////////////////////////////////////////
	// Status outputs
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			all_idle_reg <= 1'b1;
			cmd_accepted_reg <= 1'b0;
			cmd_illegal_reg <= 1'b0;
		end
		else
		begin
			all_idle_reg <= all_idle;
			cmd_accepted_reg <= cmd_ok || go_self_ref;
			// Command outside the tables or refused by a busy state
			cmd_illegal_reg <= cke_stable && is_cmd && !cmd_ok;
		end
	end

endmodule : sdbt_tracker

// ---- sdbt_tracker_asserts.sv ----
`timescale 1ns/1ns
module sdbt_chk #(
	parameter int BURST_LEN = 4,
	parameter int RP = 2,
	parameter int RCD = 2,
	parameter int RFC = 7
) (
	input wire logic clk,
	input wire logic nrst,
	input sdbt_pkg::sdbt_pins_type pins_in,
	input sdbt_pkg::sdbt_bank_state_type bank_state [sdbt_pkg::NUM_BANKS],
	input sdbt_pkg::sdbt_dev_state_type dev_state_reg,
	input wire logic all_idle_reg,
	input wire logic cmd_accepted_reg,
	input wire logic cmd_illegal_reg,
	input sdbt_pkg::sdbt_bank_idx_type burst_bank_reg
);
	import sdbt_pkg::*;
	localparam int RP_M1 = RP - 1;
	localparam int RCD_M1 = RCD - 1;
	localparam int RFC_M1 = RFC - 1;
	logic [3:0] code;
	logic cke_d_reg;
	logic live;
	sdbt_bank_state_type b0;

	////////////////////////////////////////////////////////////////////////
	// Command decode for bank 0 with clock enable high two edges
	assign code = {pins_in.cs_n, pins_in.ras_n, pins_in.cas_n, pins_in.we_n};
	assign b0 = bank_state[0];
	assign live = pins_in.cke && cke_d_reg && !pins_in.auto_precharge_addr_bit
		&& {pins_in.bank_select_bit1, pins_in.bank_select_bit0} == 2'h0;

	// Clock enable one edge back
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			cke_d_reg <= 1'h0;
		else
			cke_d_reg <= pins_in.cke;

	////////////////////////////////////////////////////////////////////////
	default clocking dc @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_inh;
		pins_in.cs_n |-> ##3 !cmd_accepted_reg && !cmd_illegal_reg;
	endproperty
	a_inh: assert property (p_inh) else $error("inhibit gave a pulse");
	property p_act;
		live && code == 4'h3 ##2 b0 == BANK_IDLE && dev_state_reg == DEV_NORMAL
			|-> ##1 b0 == BANK_ACTIVATING && cmd_accepted_reg;
	endproperty
	a_act: assert property (p_act) else $error("activate not taken");
	property p_pre;
		live && code == 4'h2 ##2 b0 == BANK_IDLE && dev_state_reg == DEV_NORMAL
			|-> ##1 b0 == BANK_IDLE && cmd_accepted_reg;
	endproperty
	a_pre: assert property (p_pre) else $error("precharge of idle bank");
	property p_bst;
		live && code == 4'h6 ##2 b0 == BANK_READ && burst_bank_reg == 2'h0 && dev_state_reg == DEV_NORMAL
			|-> ##1 b0 == BANK_ACTIVE;
	endproperty
	a_bst: assert property (p_bst) else $error("burst stop missed");
	property p_rcd;
		$rose(b0 == BANK_ACTIVATING) |-> ##RCD_M1 b0 == BANK_ACTIVATING ##1 b0 == BANK_ACTIVE;
	endproperty
	a_rcd: assert property (p_rcd) else $error("activating length");
	property p_rp;
		$rose(b0 == BANK_PRECHARGING) |-> ##RP_M1 b0 == BANK_PRECHARGING ##1 b0 == BANK_IDLE;
	endproperty
	a_rp: assert property (p_rp) else $error("precharging length");
	property p_rap;
		$rose(b0 == BANK_READ_AP) |-> ##[1:BURST_LEN] b0 == BANK_PRECHARGING;
	endproperty
	a_rap: assert property (p_rap) else $error("auto precharge missed");
	property p_ref;
		$rose(dev_state_reg == DEV_REFRESH) |-> ##RFC_M1 dev_state_reg == DEV_REFRESH ##1 dev_state_reg == DEV_NORMAL;
	endproperty
	a_ref: assert property (p_ref) else $error("refresh length");
	property p_pall;
		$rose(dev_state_reg == DEV_PRE_ALL) |-> ##RP_M1 dev_state_reg == DEV_PRE_ALL
			##1 dev_state_reg == DEV_NORMAL && b0 == BANK_IDLE;
	endproperty
	a_pall: assert property (p_pall) else $error("precharge all length");

	// Main scenarios reached
	c_rap: cover property (b0 == BANK_READ_AP);
	c_ref: cover property (dev_state_reg == DEV_REFRESH);
	c_ill: cover property (cmd_illegal_reg);
	c_slp: cover property (dev_state_reg == DEV_SR_EXIT);
endmodule : sdbt_chk

bind sdbt_tracker sdbt_chk #(.BURST_LEN(BURST_LEN), .RP(RP), .RCD(RCD), .RFC(RFC)) chk_u (
	.clk(clk), .nrst(nrst), .pins_in(pins_in), .bank_state(bank_state), .dev_state_reg(dev_state_reg),
	.all_idle_reg(all_idle_reg), .cmd_accepted_reg(cmd_accepted_reg), .cmd_illegal_reg(cmd_illegal_reg),
	.burst_bank_reg(burst_bank_reg));

// ---- sdbt_tracker_tb.sv ----
`timescale 1ns/1ns
module sdbt_tracker_tb;
	import sdbt_pkg::*;
	localparam int BL = 8;
	logic clk;
	logic nrst;
	sdbt_pins_type pins;
	sdbt_bank_state_type bank_state [NUM_BANKS];
	sdbt_dev_state_type dev_state_reg;
	logic all_idle_reg;
	logic cmd_accepted_reg;
	logic cmd_illegal_reg;
	sdbt_bank_idx_type burst_bank_reg;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;

	////////////////////////////////////////////////////////////////////////
	// Block and controller model
	sdbt_tracker #(.BURST_LEN(BL)) dut_u (.clk(clk), .nrst(nrst), .pins_in(pins), .bank_state(bank_state),
		.dev_state_reg(dev_state_reg), .all_idle_reg(all_idle_reg), .cmd_accepted_reg(cmd_accepted_reg),
		.cmd_illegal_reg(cmd_illegal_reg), .burst_bank_reg(burst_bank_reg));
	sdbt_host host_u (.clk(clk), .all_idle(all_idle_reg), .pins(pins));

	// Clock
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		if (fail_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	task automatic bad(input string m);
		fail_count++;
		$display("BAD %0t %s", $time, m);
	endtask : bad
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic cb(input int b, input sdbt_bank_state_type s);
		tests_run++;
		if (bank_state[b] !== s)
			bad($sformatf("bank %0d state %0h", b, bank_state[b]));
	endtask : cb
	task automatic cd(input sdbt_dev_state_type s);
		tests_run++;
		if (dev_state_reg !== s)
			bad("device state");
	endtask : cd
	// One command, then its answer compared while the pulses stand
	task automatic go(input logic [3:0] c, input logic [1:0] b, input logic ap, input logic [1:0] pl);
		host_u.put(c, b, ap);
		host_u.fill(1);
		step(2);
		tests_run++;
		if ({cmd_accepted_reg, cmd_illegal_reg} !== pl)
			bad("command pulses");
	endtask : go

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int b = 0; b < NUM_BANKS; b++)
			cb(b, BANK_IDLE);
		cd(DEV_NORMAL);
		tests_run++;
		if (all_idle_reg !== 1'h1 || burst_bank_reg !== 2'h0)
			bad("reset outputs");
	endtask : t_reset
	task automatic t_quiet;
		go(4'hB, 2'h0, 1'h0, 2'h0);
		cb(0, BANK_IDLE);
		go(4'h7, 2'h0, 1'h0, 2'h0);
		go(4'h2, 2'h0, 1'h0, 2'h2);
		cb(0, BANK_IDLE);
	endtask : t_quiet
	task automatic t_burst;
		go(4'h3, 2'h0, 1'h0, 2'h2);
		cb(0, BANK_ACTIVATING);
		cb(1, BANK_IDLE);
		step(RCD_CYC - 1);
		cb(0, BANK_ACTIVATING);
		step(1);
		cb(0, BANK_ACTIVE);
		go(4'h3, 2'h0, 1'h0, 2'h1);
		go(4'h5, 2'h0, 1'h0, 2'h2);
		cb(0, BANK_READ);
		go(4'h4, 2'h0, 1'h0, 2'h2);
		cb(0, BANK_WRITE);
		go(4'h5, 2'h0, 1'h0, 2'h2);
		cb(0, BANK_READ);
		go(4'h6, 2'h0, 1'h0, 2'h2);
		cb(0, BANK_ACTIVE);
		go(4'h4, 2'h0, 1'h0, 2'h2);
		go(4'h2, 2'h0, 1'h0, 2'h2);
		cb(0, BANK_PRECHARGING);
		step(RP_CYC - 1);
		cb(0, BANK_PRECHARGING);
		step(1);
		cb(0, BANK_IDLE);
	endtask : t_burst
	task automatic t_ap;
		for (int i = 0; i < 2; i++)
		begin
			go(4'h3, 2'h0, 1'h0, 2'h2);
			step(RCD_CYC);
			go(i ? 4'h4 : 4'h5, 2'h0, 1'h1, 2'h2);
			cb(0, i ? BANK_WRITE_AP : BANK_READ_AP);
			step(BL - 1);
			cb(0, i ? BANK_WRITE_AP : BANK_READ_AP);
			step(1);
			cb(0, BANK_PRECHARGING);
			step(RP_CYC);
			cb(0, BANK_IDLE);
		end
	endtask : t_ap
	task automatic t_cross;
		host_u.put(4'h3, 2'h3, 1'h0);
		host_u.put(4'h3, 2'h2, 1'h0);
		host_u.fill(1);
		step(2);
		cb(3, BANK_ACTIVATING);
		cb(2, BANK_ACTIVATING);
		cb(0, BANK_IDLE);
		step(RCD_CYC);
		go(4'h5, 2'h2, 1'h0, 2'h2);
		go(4'h5, 2'h3, 1'h0, 2'h2);
		cb(2, BANK_ACTIVE);
		cb(3, BANK_READ);
		tests_run++;
		if (burst_bank_reg !== 2'h3)
			bad("burst bank");
		go(4'h2, 2'h0, 1'h1, 2'h2);
		cd(DEV_PRE_ALL);
		cb(2, BANK_PRECHARGING);
		step(RP_CYC);
		cd(DEV_NORMAL);
		cb(3, BANK_IDLE);
	endtask : t_cross
	task automatic t_dev;
		go(4'h1, 2'h0, 1'h0, 2'h2);
		cd(DEV_REFRESH);
		go(4'h3, 2'h0, 1'h0, 2'h1);
		cb(0, BANK_IDLE);
		step(RFC_CYC - 4);
		cd(DEV_REFRESH);
		step(1);
		cd(DEV_NORMAL);
		go(4'h0, 2'h0, 1'h0, 2'h2);
		cd(DEV_MODE);
		step(MRD_CYC - 1);
		cd(DEV_MODE);
		step(1);
		cd(DEV_NORMAL);
	endtask : t_dev
	// Self refresh entry, exit delay, commands refused until it ends
	task automatic t_sleep;
		host_u.sleep(3);
		step(1);
		cd(DEV_SELF_REF);
		tests_run++;
		if (all_idle_reg !== 1'h0)
			bad("idle in self refresh");
		step(2);
		cd(DEV_SR_EXIT);
		go(4'h3, 2'h0, 1'h0, 2'h1);
		cb(0, BANK_IDLE);
		step(XSR_CYC - 4);
		cd(DEV_SR_EXIT);
		step(1);
		cd(DEV_NORMAL);
	endtask : t_sleep

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		nrst = 1'h0;
		repeat (10) @(negedge clk);
		nrst = 1'h1;
		step(5);
		t_reset();
		t_quiet();
		t_burst();
		t_ap();
		t_cross();
		t_dev();
		t_sleep();
		close_out();
	end

	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			bad("timeout");
			close_out();
		end
	end
endmodule : sdbt_tracker_tb
